/* File: hdl/psor_pkg.sv */
`default_nettype none
package psor_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [6:0] PSOR_OFS_FIFO_CTRL = 7'h13;
	localparam logic [6:0] PSOR_OFS_FIFO_WTM  = 7'h14;
	localparam logic [6:0] PSOR_OFS_REF_LO    = 7'h15;
	localparam logic [6:0] PSOR_OFS_REF_HI    = 7'h16;
	localparam logic [6:0] PSOR_OFS_POFS_LO   = 7'h18;
	localparam logic [6:0] PSOR_OFS_POFS_HI   = 7'h19;
	localparam logic [6:0] PSOR_OFS_INT_SRC   = 7'h24;
	localparam logic [6:0] PSOR_OFS_FIFO_LVL  = 7'h25;
	localparam logic [6:0] PSOR_OFS_FIFO_FLG  = 7'h26;
	localparam logic [6:0] PSOR_OFS_CONV_STS  = 7'h27;
	localparam logic [6:0] PSOR_OFS_PRESSURE_RESULT_BITS_LO   = 7'h28;
	localparam logic [6:0] PSOR_OFS_PRESSURE_RESULT_BITS_MID  = 7'h29;
	localparam logic [6:0] PSOR_OFS_PRESSURE_RESULT_BITS_HI   = 7'h2A;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int PSOR_BIT_HALT      = 3;
	localparam int PSOR_BIT_BOOT_ON   = 7;
	localparam int PSOR_BIT_IA        = 2;
	localparam int PSOR_BIT_PL        = 1;
	localparam int PSOR_BIT_PH        = 0;
	localparam int PSOR_BIT_WTM_FLG   = 7;
	localparam int PSOR_BIT_OVR_FLG   = 6;
	localparam int PSOR_BIT_FULL_FLG  = 5;
	localparam int PSOR_BIT_T_OR      = 5;
	localparam int PSOR_BIT_P_OR      = 4;
	localparam int PSOR_BIT_T_DA      = 1;
	localparam int PSOR_BIT_P_DA      = 0;
	// ---------------------------------------------------------------
	// Reset values and sizes
	// ---------------------------------------------------------------
	localparam logic [7:0]  PSOR_RST_BYTE  = 8'h00;
	localparam logic [15:0] PSOR_RST_WORD  = 16'h0000;
	localparam logic [6:0]  PSOR_RST_WTM   = 7'h00;
	localparam logic [23:0] PSOR_RST_PRESSURE_RESULT_BITS  = 24'h000000;
	localparam logic [7:0]  PSOR_FIFO_SIZE = 8'h80;
	localparam int          PSOR_FRAME_BITS = 16;
	localparam int          PSOR_HDR_BITS   = 8;
endpackage
`default_nettype wire

/* File: hdl/psor_link.sv */
`default_nettype none
module psor_link
	import psor_pkg::*;
(
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       arst_n,
	input  wire logic       mosi,
	output var  logic       miso_o,
	output var  logic       miso_oe,
	output var  logic       wr_tgl,
	output var  logic [6:0] wr_addr,
	output var  logic [7:0] wr_data,
	output var  logic       rd_tgl,
	output var  logic [6:0] rd_addr,
	input  wire logic       rd_ack_tgl,
	input  wire logic [7:0] rd_data
);
	// ---------------------------------------------------------------
	// Frame counter and receive shifter, cleared between frames
	// ---------------------------------------------------------------
	logic [4:0] cnt_r;
	logic [6:0] rx_r;
	logic       rw_r;
	logic [6:0] hdr_addr_r;
	logic [7:0] tx_r;
	logic       ack_s1_r;
	logic       ack_s2_r;

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			cnt_r      <= 5'h00;
			rx_r       <= 7'h00;
			rw_r       <= 1'b0;
			hdr_addr_r <= 7'h00;
		end else begin
			if (cnt_r != 5'(PSOR_FRAME_BITS))
				cnt_r <= cnt_r + 5'h01;
			rx_r <= {rx_r[5:0], mosi};
			if (cnt_r == 5'(PSOR_HDR_BITS - 1)) begin
				rw_r       <= rx_r[6];
				hdr_addr_r <= {rx_r[5:0], mosi};
			end
		end
	end

	// ---------------------------------------------------------------
	// Acknowledge synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end else begin
			ack_s1_r <= rd_ack_tgl;
			ack_s2_r <= ack_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Requests toward the register domain
	// ---------------------------------------------------------------
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_tgl  <= 1'b0;
			wr_addr <= 7'h00;
			wr_data <= 8'h00;
			rd_tgl  <= 1'b0;
			rd_addr <= 7'h00;
			tx_r    <= 8'h00;
		end else begin
			if (!cs_n && cnt_r == 5'(PSOR_HDR_BITS - 1) && rx_r[6]) begin
				tx_r    <= (ack_s2_r == rd_tgl) ? rd_data : 8'h00;
				rd_addr <= {rx_r[5:0], mosi};
				rd_tgl  <= ~rd_tgl;
			end else if (!cs_n && cnt_r >= 5'(PSOR_HDR_BITS)
				&& cnt_r < 5'(PSOR_FRAME_BITS - 1)) begin
				tx_r <= {tx_r[6:0], 1'b0};
			end
			if (!cs_n && cnt_r == 5'(PSOR_FRAME_BITS - 1) && !rw_r) begin
				wr_addr <= hdr_addr_r;
				wr_data <= {rx_r[6:0], mosi};
				wr_tgl  <= ~wr_tgl;
			end
		end
	end

	// ---------------------------------------------------------------
	// Serial output, changes on the falling edge
	// ---------------------------------------------------------------
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			miso_o  <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			miso_o  <= tx_r[7];
			miso_oe <= rw_r && cnt_r >= 5'(PSOR_HDR_BITS)
				&& cnt_r < 5'(PSOR_FRAME_BITS);
		end
	end
endmodule
`default_nettype wire

/* File: hdl/psor_regs.sv */
`default_nettype none
// Notes on behaviour
// R1: 16-bit signed reference pressure in two bytes, both reset to zero.
// R2: Reference is captured and used only while auto zeroing or auto reference is on.
// R3: 16-bit signed pressure offset, writable low and high bytes, reset to zero.
// R4: Boot indicator reads 1 while trimming reload runs, 0 after.
// R5: Interrupt-active flag is 1 whenever any interrupt event is pending.
// R6: Separate sticky flags for high and low differential pressure events.
// R7: Unread FIFO sample count reported as an 8-bit value, 0 to 128.
// R8: Watermark flag is 1 while fill level is at or above threshold.
// R9: Overrun flag is 1 once FIFO full and a sample was overwritten.
// R10: Full flag is 1 when FIFO completely filled and nothing overwritten.
// R11: Pressure and temperature overrun flags set when unread result is replaced.
// R12: Pressure and temperature data-available flags set on a new result.
// R13: Conversion status updates once per output data rate period.
// R14: Pressure result is 24-bit signed, three read-only bytes at 28h..2Ah.
// R15: With all relative modes and differential mode off, output is measured pressure minus offset.
// R16: 7-bit watermark threshold field, reset to zero, feeds the watermark flag.
// R17: With halt at threshold on, FIFO counts full at the watermark level.
// R18: Result bytes hold their value until the next conversion completes.
// R19: Host writes both offset bytes before trusting the corrected output.
module psor_regs
	import psor_pkg::*;
#(
	parameter int REF_SHIFT = 8
)(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	output var  logic        miso_o,
	output var  logic        miso_oe,
	input  wire logic        conv_done,
	input  wire logic [23:0] press_raw,
	input  wire logic        temp_done,
	input  wire logic        temp_read,
	input  wire logic        trim_loading,
	input  wire logic        press_high_evt,
	input  wire logic        press_low_evt,
	input  wire logic [7:0]  fifo_unread_count,
	input  wire logic        fifo_overwrite_evt,
	input  wire logic        automatic_zeroing,
	input  wire logic        automatic_reference,
	input  wire logic        differential_mode_enable,
	output var  logic [23:0] pressure_result_bits,
	output var  logic [6:0]  watermark_threshold,
	output var  logic        halt_at_threshold,
	output var  logic        fifo_completely_filled
);
	if (REF_SHIFT < 0 || REF_SHIFT > 8) begin
		$error("REF_SHIFT out of range");
	end

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Serial link
	// ---------------------------------------------------------------
	logic       wr_tgl;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic       rd_tgl;
	logic [6:0] rd_addr;
	logic       rd_ack_r;
	logic [7:0] rd_data_r;

	psor_link u_link (
		.sclk       (sclk),
		.cs_n       (cs_n),
		.arst_n     (arst_n),
		.mosi       (mosi),
		.miso_o     (miso_o),
		.miso_oe    (miso_oe),
		.wr_tgl     (wr_tgl),
		.wr_addr    (wr_addr),
		.wr_data    (wr_data),
		.rd_tgl     (rd_tgl),
		.rd_addr    (rd_addr),
		.rd_ack_tgl (rd_ack_r),
		.rd_data    (rd_data_r)
	);

	logic [2:0] wr_sync_r;
	logic [2:0] rd_sync_r;
	logic       wr_evt;
	logic       rd_evt;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_sync_r <= 3'h0;
			rd_sync_r <= 3'h0;
		end else begin
			wr_sync_r <= {wr_sync_r[1:0], wr_tgl};
			rd_sync_r <= {rd_sync_r[1:0], rd_tgl};
		end
	end

	assign wr_evt = wr_sync_r[2] ^ wr_sync_r[1];
	assign rd_evt = rd_sync_r[2] ^ rd_sync_r[1];

	function automatic logic hit(input logic evt, input logic [6:0] a, input logic [6:0] o);
		hit = evt && (a == o);
	endfunction

	// ---------------------------------------------------------------
	// Writable registers
	// ---------------------------------------------------------------
	logic [15:0] ofs_r;
	logic [7:0]  fctl_r;

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ofs_r               <= PSOR_RST_WORD;
			fctl_r              <= PSOR_RST_BYTE;
			watermark_threshold <= PSOR_RST_WTM;
		end else begin
			if (hit(wr_evt, wr_addr, PSOR_OFS_POFS_LO))
				ofs_r[7:0] <= wr_data;                           // [R3]
			if (hit(wr_evt, wr_addr, PSOR_OFS_POFS_HI))
				ofs_r[15:8] <= wr_data;                          // [R3]
			if (hit(wr_evt, wr_addr, PSOR_OFS_FIFO_CTRL))
				fctl_r <= wr_data;
			if (hit(wr_evt, wr_addr, PSOR_OFS_FIFO_WTM))
				watermark_threshold <= wr_data[6:0];             // [R16]
		end
	end

	assign halt_at_threshold = fctl_r[PSOR_BIT_HALT];

	// ---------------------------------------------------------------
	// Reference capture and result
	// ---------------------------------------------------------------
	logic        rel_on;
	logic        rel_d_r;
	logic        ref_arm_r;
	logic [15:0] ref_r;
	logic [23:0] ofs_corr;
	logic [23:0] ref_corr;
	logic [23:0] result_nxt;

	assign rel_on   = automatic_zeroing || automatic_reference;
	assign ofs_corr = press_raw - (24'({{8{ofs_r[15]}}, ofs_r}) << REF_SHIFT);
	assign ref_corr = press_raw - (24'({{8{ref_r[15]}}, ref_r}) << REF_SHIFT);

	always_comb begin
		if (rel_on)
			result_nxt = ref_corr;                               // [R2]
		else if (differential_mode_enable)
			result_nxt = press_raw;
		else
			result_nxt = ofs_corr;                               // [R15]
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rel_d_r   <= 1'b0;
			ref_arm_r <= 1'b0;
			ref_r     <= PSOR_RST_WORD;
		end else begin
			rel_d_r <= rel_on;
			if (rel_on && !rel_d_r)
				ref_arm_r <= 1'b1;
			else if (conv_done || !rel_on)
				ref_arm_r <= 1'b0;
			if (rel_on && conv_done && (ref_arm_r || !rel_d_r))
				ref_r <= press_raw[23:8];                        // [R1] [R2]
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r)
			pressure_result_bits <= PSOR_RST_PRESSURE_RESULT_BITS;
		else if (conv_done)
			pressure_result_bits <= result_nxt;                  // [R14] [R18]
	end

	// ---------------------------------------------------------------
	// Interrupt source flags, cleared by reading
	// ---------------------------------------------------------------
	logic ph_r;
	logic pl_r;
	logic ia;
	logic clr_int;

	assign clr_int = hit(rd_evt, rd_addr, PSOR_OFS_INT_SRC);
	assign ia      = ph_r || pl_r;                               // [R5]

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ph_r <= 1'b0;
			pl_r <= 1'b0;
		end else begin
			ph_r <= press_high_evt || (ph_r && !clr_int);        // [R6]
			pl_r <= press_low_evt || (pl_r && !clr_int);         // [R6]
		end
	end

	// ---------------------------------------------------------------
	// FIFO status
	// ---------------------------------------------------------------
	logic       fifo_ovr_r;
	logic       wtm_flag;
	logic       fifo_at_top;

	assign wtm_flag    = fifo_unread_count >= {1'b0, watermark_threshold};  // [R8]
	assign fifo_at_top = halt_at_threshold ?
		(fifo_unread_count == {1'b0, watermark_threshold}) :     // [R17]
		(fifo_unread_count >= PSOR_FIFO_SIZE);

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r)
			fifo_ovr_r <= 1'b0;
		else
			fifo_ovr_r <= fifo_at_top && (fifo_overwrite_evt || fifo_ovr_r);  // [R9]
	end

	assign fifo_completely_filled = fifo_at_top && !fifo_ovr_r;  // [R10]

	// ---------------------------------------------------------------
	// Conversion status
	// ---------------------------------------------------------------
	logic pda_r;
	logic tda_r;
	logic por_r;
	logic tor_r;
	logic clr_p;

	assign clr_p = hit(rd_evt, rd_addr, PSOR_OFS_PRESSURE_RESULT_BITS_HI);

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pda_r <= 1'b0;
			tda_r <= 1'b0;
			por_r <= 1'b0;
			tor_r <= 1'b0;
		end else begin
			pda_r <= conv_done || (pda_r && !clr_p);                      // [R12] [R13]
			tda_r <= temp_done || (tda_r && !temp_read);                  // [R12] [R13]
			por_r <= (conv_done && pda_r && !clr_p) || (por_r && !clr_p); // [R11]
			tor_r <= (temp_done && tda_r && !temp_read)
				|| (tor_r && !temp_read);                                 // [R11]
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	function automatic logic [7:0] read_value(input logic [6:0] a);
		case (a)
			PSOR_OFS_FIFO_CTRL: read_value = fctl_r;
			PSOR_OFS_FIFO_WTM:  read_value = {1'b0, watermark_threshold};
			PSOR_OFS_REF_LO:    read_value = ref_r[7:0];
			PSOR_OFS_REF_HI:    read_value = ref_r[15:8];
			PSOR_OFS_POFS_LO:   read_value = ofs_r[7:0];
			PSOR_OFS_POFS_HI:   read_value = ofs_r[15:8];
			PSOR_OFS_INT_SRC:   read_value = 8'((32'(trim_loading) << PSOR_BIT_BOOT_ON)
				| (32'(ia) << PSOR_BIT_IA) | (32'(pl_r) << PSOR_BIT_PL)
				| (32'(ph_r) << PSOR_BIT_PH));                    // [R4] [R5]
			PSOR_OFS_FIFO_LVL:  read_value = fifo_unread_count;  // [R7]
			PSOR_OFS_FIFO_FLG:  read_value = 8'((32'(wtm_flag) << PSOR_BIT_WTM_FLG)
				| (32'(fifo_ovr_r) << PSOR_BIT_OVR_FLG)
				| (32'(fifo_completely_filled) << PSOR_BIT_FULL_FLG));
			PSOR_OFS_CONV_STS:  read_value = 8'((32'(tor_r) << PSOR_BIT_T_OR)
				| (32'(por_r) << PSOR_BIT_P_OR) | (32'(tda_r) << PSOR_BIT_T_DA)
				| (32'(pda_r) << PSOR_BIT_P_DA));
			PSOR_OFS_PRESSURE_RESULT_BITS_LO:   read_value = pressure_result_bits[7:0];
			PSOR_OFS_PRESSURE_RESULT_BITS_MID:  read_value = pressure_result_bits[15:8];
			PSOR_OFS_PRESSURE_RESULT_BITS_HI:   read_value = pressure_result_bits[23:16];
			default:            read_value = 8'h00;
		endcase
	endfunction

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rd_data_r <= 8'h00;
			rd_ack_r  <= 1'b0;
		end else if (rd_evt) begin
			rd_data_r <= read_value(rd_addr);
			rd_ack_r  <= ~rd_ack_r;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [7:0] int_view;
	logic [7:0] flg_view;
	logic [7:0] sts_view;

	always_comb begin
		int_view = read_value(PSOR_OFS_INT_SRC);
		flg_view = read_value(PSOR_OFS_FIFO_FLG);
		sts_view = read_value(PSOR_OFS_CONV_STS);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_r);

	chk_ref_frozen_off: assert property (!rel_on |=> $stable(ref_r)) // [R2]
		else $error("reference changed while relative modes off");
	chk_result_hold: assert property (!conv_done |=> $stable(pressure_result_bits)) // [R18]
		else $error("result changed without conversion");
	chk_offset_sub: assert property ( // [R15]
		conv_done && !rel_on && !differential_mode_enable
		|=> pressure_result_bits == $past(ofs_corr))
		else $error("result is not pressure minus offset");
	chk_pda_set: assert property (conv_done |=> pda_r && sts_view[PSOR_BIT_P_DA]) // [R12]
		else $error("pressure available not set");
	chk_por_set: assert property (conv_done && pda_r && !clr_p |=> por_r) // [R11]
		else $error("pressure overrun not set");
	chk_ia_any: assert property ((ph_r || pl_r) == int_view[PSOR_BIT_IA]) // [R5]
		else $error("interrupt active mismatch");
	chk_ph_sticky: assert property (press_high_evt |=> (ph_r [*2]) or (ph_r && clr_int)) // [R6]
		else $error("high pressure flag lost");
	chk_wtm_level: assert property ( // [R8]
		flg_view[PSOR_BIT_WTM_FLG] == (fifo_unread_count >= {1'b0, watermark_threshold}))
		else $error("watermark flag mismatch");
	chk_full_excl: assert property (fifo_ovr_r |-> !fifo_completely_filled) // [R10]
		else $error("full and overrun both set");
	chk_ovr_set: assert property (fifo_at_top && fifo_overwrite_evt |=> fifo_ovr_r) // [R9]
		else $error("fifo overrun not set");
	chk_halt_full: assert property ( // [R17]
		halt_at_threshold && fifo_unread_count == {1'b0, watermark_threshold} && !fifo_ovr_r
		|-> fifo_completely_filled)
		else $error("full not reported at threshold");
	chk_boot_show: assert property (int_view[PSOR_BIT_BOOT_ON] == trim_loading) // [R4]
		else $error("boot indicator mismatch");
	chk_ofs_write: assert property (
		hit(wr_evt, wr_addr, PSOR_OFS_POFS_HI) |=> ofs_r[15:8] == $past(wr_data)) // [R3]
		else $error("offset high byte not written");
endmodule
`default_nettype wire

/* File: tb/psor_host.sv */
`default_nettype none
module psor_host (
	output var  logic sclk,
	output var  logic cs_n,
	output var  logic mosi,
	input  wire logic miso_o,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// Link timing: 30 ns clock within frames, still between them
	// ---------------------------------------------------------------
	localparam int HALF = 15;
	localparam int GAP  = 1000;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ---------------------------------------------------------------
	// One frame: rw, address, data, MSB first; returns data-phase bits
	// ---------------------------------------------------------------
	task automatic frame(input logic rw, input logic [6:0] addr, input logic [7:0] wdata,
			output logic [7:0] rdata);
		logic [15:0] word;
		word = {rw, addr, wdata};
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = word[i];
			#HALF sclk = 1'b1;
			if (i < 8)
				rdata[i] = miso_oe ? miso_o : 1'bx;
			#HALF sclk = 1'b0;
		end
		#HALF cs_n = 1'b1;
		mosi = ~mosi;
		#GAP;
	endtask
endmodule
`default_nettype wire

/* File: tb/pressure_status_output_regs_test.sv */
`default_nettype none
module pressure_status_output_regs_test;
	import psor_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        conv_done = 1'b0;
	logic [23:0] press_raw = 24'h000000;
	logic        temp_done = 1'b0;
	logic        temp_read = 1'b0;
	logic        trim_loading = 1'b0;
	logic        press_high_evt = 1'b0;
	logic        press_low_evt = 1'b0;
	logic [7:0]  fifo_unread_count = 8'h00;
	logic        fifo_overwrite_evt = 1'b0;
	logic        automatic_zeroing = 1'b0;
	logic        automatic_reference = 1'b0;
	logic        differential_mode_enable = 1'b0;
	wire         sclk;
	wire         cs_n;
	wire         mosi;
	wire         miso_o;
	wire         miso_oe;
	wire  [23:0] pressure_result_bits;
	wire  [6:0]  watermark_threshold;
	wire         halt_at_threshold;
	wire         fifo_completely_filled;
	int          errors = 0;
	int          tests_run = 0;
	int          cycles = 0;

	always #50 clk = ~clk;

	psor_regs dut (
		.clk                      (clk),
		.arst_n                   (arst_n),
		.sclk                     (sclk),
		.cs_n                     (cs_n),
		.mosi                     (mosi),
		.miso_o                   (miso_o),
		.miso_oe                  (miso_oe),
		.conv_done                (conv_done),
		.press_raw                (press_raw),
		.temp_done                (temp_done),
		.temp_read                (temp_read),
		.trim_loading             (trim_loading),
		.press_high_evt           (press_high_evt),
		.press_low_evt            (press_low_evt),
		.fifo_unread_count        (fifo_unread_count),
		.fifo_overwrite_evt       (fifo_overwrite_evt),
		.automatic_zeroing        (automatic_zeroing),
		.automatic_reference      (automatic_reference),
		.differential_mode_enable (differential_mode_enable),
		.pressure_result_bits     (pressure_result_bits),
		.watermark_threshold      (watermark_threshold),
		.halt_at_threshold        (halt_at_threshold),
		.fifo_completely_filled   (fifo_completely_filled)
	);

	psor_host host (
		.sclk    (sclk),
		.cs_n    (cs_n),
		.mosi    (mosi),
		.miso_o  (miso_o),
		.miso_oe (miso_oe)
	);

	// ---------------------------------------------------------------
	// Shared helpers
	// ---------------------------------------------------------------
	task automatic end_of_test();
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n = 1);
		repeat (n) @(posedge clk);
		#5;
	endtask

	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		logic [7:0] unused;
		host.frame(1'b0, addr, data, unused);
		step();
	endtask

	// Reads are pipelined: the second frame carries the first one's data
	task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		host.frame(1'b1, addr, 8'h00, d);
		host.frame(1'b1, 7'h00, 8'h00, d);
		check({16'h0000, d}, {16'h0000, exp});
		step();
	endtask

	task automatic conv(input logic [23:0] raw);
		press_raw = raw;
		conv_done = 1'b1;
		step();
		conv_done = 1'b0;
		step(2);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		logic [6:0] adr [10] = '{7'h15, 7'h16, 7'h18, 7'h19, 7'h24, 7'h25, 7'h27,
			7'h28, 7'h29, 7'h2A};
		check(pressure_result_bits, 24'h000000);
		check({17'h00000, watermark_threshold}, 24'h000000);
		foreach (adr[i])
			rd_chk(adr[i], 8'h00);
	endtask

	task automatic t_offset();
		wr(7'h18, 8'h34);
		wr(7'h19, 8'h12);
		rd_chk(7'h18, 8'h34);
		rd_chk(7'h19, 8'h12);
		wr(7'h15, 8'hFF);
		wr(7'h16, 8'hFF);
		rd_chk(7'h15, 8'h00);
		rd_chk(7'h16, 8'h00);
		rd_chk(7'h30, 8'h00);
	endtask

	task automatic t_result();
		conv(24'h345678);
		check(pressure_result_bits, 24'h222278);
		rd_chk(7'h28, 8'h78);
		rd_chk(7'h29, 8'h22);
		press_raw = 24'h000000;
		step(4);
		rd_chk(7'h2A, 8'h22);
		wr(7'h18, 8'hFF);
		wr(7'h19, 8'hFF);
		conv(24'h100000);
		check(pressure_result_bits, 24'h100100);
	endtask

	task automatic t_status();
		rd_chk(7'h2A, 8'h10);
		rd_chk(7'h27, 8'h00);
		conv(24'h100000);
		rd_chk(7'h27, 8'h01);
		conv(24'h100000);
		temp_done = 1'b1;
		step();
		temp_done = 1'b0;
		rd_chk(7'h27, 8'h13);
		temp_done = 1'b1;
		step();
		temp_done = 1'b0;
		rd_chk(7'h27, 8'h33);
		rd_chk(7'h2A, 8'h10);
		rd_chk(7'h27, 8'h22);
		temp_read = 1'b1;
		step();
		temp_read = 1'b0;
		rd_chk(7'h27, 8'h00);
	endtask

	task automatic t_irq();
		trim_loading = 1'b1;
		step();
		rd_chk(7'h24, 8'h80);
		press_high_evt = 1'b1;
		step();
		press_high_evt = 1'b0;
		rd_chk(7'h24, 8'h85);
		rd_chk(7'h24, 8'h80);
		trim_loading = 1'b0;
		press_low_evt = 1'b1;
		step();
		press_low_evt = 1'b0;
		rd_chk(7'h24, 8'h06);
		rd_chk(7'h24, 8'h00);
	endtask

	task automatic t_fifo();
		wr(7'h14, 8'h10);
		check({17'h00000, watermark_threshold}, 24'h000010);
		fifo_unread_count = 8'h0F;
		step();
		rd_chk(7'h26, 8'h00);
		rd_chk(7'h25, 8'h0F);
		fifo_unread_count = 8'h10;
		step();
		rd_chk(7'h26, 8'h80);
		fifo_unread_count = 8'h80;
		step();
		rd_chk(7'h25, 8'h80);
		rd_chk(7'h26, 8'hA0);
		check({23'h000000, fifo_completely_filled}, 24'h000001);
		fifo_overwrite_evt = 1'b1;
		step();
		fifo_overwrite_evt = 1'b0;
		rd_chk(7'h26, 8'hC0);
		fifo_unread_count = 8'h10;
		step();
		check({23'h000000, fifo_completely_filled}, 24'h000000);
		wr(7'h13, 8'h08);
		check({23'h000000, halt_at_threshold}, 24'h000001);
		check({23'h000000, fifo_completely_filled}, 24'h000001);
		fifo_unread_count = 8'h0F;
		step();
		check({23'h000000, fifo_completely_filled}, 24'h000000);
		wr(7'h13, 8'h00);
	endtask

	task automatic t_ref();
		automatic_zeroing = 1'b1;
		step();
		conv(24'hABCD12);
		rd_chk(7'h15, 8'hCD);
		rd_chk(7'h16, 8'hAB);
		conv(24'hABCE12);
		check(pressure_result_bits, 24'h000112);
		automatic_zeroing = 1'b0;
		step();
		conv(24'h200000);
		check(pressure_result_bits, 24'h200100);
		automatic_reference = 1'b1;
		step();
		conv(24'h123456);
		rd_chk(7'h15, 8'h34);
		rd_chk(7'h16, 8'h12);
		automatic_reference = 1'b0;
		step();
		conv(24'h200000);
		check(pressure_result_bits, 24'h200100);
		differential_mode_enable = 1'b1;
		step();
		conv(24'h0A0B0C);
		check(pressure_result_bits, 24'h0A0B0C);
		differential_mode_enable = 1'b0;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		step(12);
		arst_n = 1'b1;
		step(3);
		t_reset();
		t_offset();
		t_result();
		t_status();
		t_irq();
		t_fifo();
		t_ref();
		end_of_test();
	end
endmodule
`default_nettype wire
